//--- inc/rds_pkg.sv
// Constants and types for the reading data store control block
package rds_pkg;
  localparam int          RDW           = 24;
  localparam int          AW            = 9;
  localparam int          IW            = 24;
  localparam int          STORE_DEPTH   = 500;
  localparam logic [AW-1:0] STORE_LAST  = 9'h1f3;
  localparam logic [AW-1:0] SIZE_MAX    = 9'h1f4;
  localparam logic [IW-1:0] IVL_MAX     = 24'h98967f;
  localparam logic [IW-1:0] IVL_HS_MAX  = 24'h000004;
  localparam logic [IW-1:0] IVL_LC_MIN  = 24'h000028;
  localparam int          CLK_HZ        = 25000000;
  localparam int          MS_PER_S      = 1000;
  localparam int          MS_CYC        = CLK_HZ / MS_PER_S;
  localparam logic [15:0] MS_CYC_M1     = 16'(MS_CYC - 1);
  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_IVL    = 8'h04;
  localparam logic [7:0] OFS_SIZE   = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0c;
  localparam logic [7:0] OFS_OUT    = 8'h10;
  localparam logic [7:0] OFS_MAX    = 8'h14;
  localparam logic [7:0] OFS_MIN    = 8'h18;
  localparam logic [7:0] OFS_AVG    = 8'h1c;
  localparam logic [7:0] OFS_COUNT  = 8'h20;
  // CTRL fields
  localparam int CTRL_SRC    = 0;
  localparam int CTRL_TMODE  = 4;
  localparam int CTRL_HSOK   = 8;
  localparam int CTRL_LINE   = 9;
  localparam int CTRL_START  = 12;
  localparam int CTRL_ERRCLR = 13;
  // Reset values
  localparam logic            RST_SRC   = 1'b0;
  localparam logic [2:0]      RST_TMODE = 3'h0;
  localparam logic [IW-1:0]   RST_IVL   = 24'h000000;
  localparam logic [AW-1:0]   RST_SIZE  = 9'h000;
  typedef enum logic [1:0] {RDS_IDLE, RDS_ARMED, RDS_RUN, RDS_FULL} rds_state_t;
endpackage : rds_pkg

//--- hw/rds_ctrl.sv
// Reading data store controller with APB register slave
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module rds_ctrl (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic [31:0]              paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     dev_clear,
  input  wire logic                     func_change,
  input  wire logic                     conv_done,
  input  wire logic [rds_pkg::RDW-1:0]  conv_data,
  input  wire logic                     talk_addr,
  input  wire logic                     get_cmd,
  input  wire logic                     exec_char,
  input  wire logic                     ext_trig,
  input  wire logic                     out_take,
  output logic [rds_pkg::RDW-1:0]       out_data,
  output logic                          store_full,
  output logic                          illegal_option_error,
  output logic                          short_period_error
);
  import rds_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic            src_q;
  logic [2:0]      tmode_q;
  logic            hsok_q;
  logic            line_q;
  logic [IW-1:0]   ivl_q;
  logic [AW-1:0]   size_q;
  logic            ioe_q;
  logic            spe_q;
  rds_state_t      st_q;
  logic [AW-1:0]   wptr_q;
  logic [AW-1:0]   rptr_q;
  logic [AW-1:0]   cnt_q;
  logic [RDW-1:0]  mem [STORE_DEPTH];
  logic [RDW-1:0]  max_q;
  logic [RDW-1:0]  min_q;
  logic [RDW-1:0]  live_q;
  logic [RDW-1:0]  rd_word;
  logic [RDW+AW-1:0] sum_q;
  logic [15:0]     ms_q;
  logic [IW-1:0]   ivl_cnt_q;
  logic            ext_s1_q;
  logic            ext_s2_q;
  logic            ext_s3_q;

  wire       acc      = psel & penable;
  wire       wr       = acc & pwrite;
  wire [7:0] ofs      = paddr[7:0];
  wire       full_wd  = &pstrb;
  wire       wr_ctrl  = wr & full_wd & (ofs == OFS_CTRL);
  wire       wr_ivl   = wr & full_wd & (ofs == OFS_IVL);
  wire       wr_size  = wr & full_wd & (ofs == OFS_SIZE);
  // Upper bits must be clear too, else a huge value would alias a legal one
  wire       ivl_hi0  = pwdata[31:IW] == '0;
  wire       size_hi0 = pwdata[31:AW] == '0;
  wire       ivl_ok   = ivl_hi0 & (pwdata[IW-1:0] <= IVL_MAX);
  wire       size_ok  = size_hi0 & (pwdata[AW-1:0] <= SIZE_MAX);
  // A start is judged on the settings written with it, not the old ones
  wire [2:0] cfg_tmode = wr_ctrl ? pwdata[CTRL_TMODE+2:CTRL_TMODE] : tmode_q;
  wire       cfg_hsok = wr_ctrl ? pwdata[CTRL_HSOK] : hsok_q;
  wire       cfg_line = wr_ctrl ? pwdata[CTRL_LINE] : line_q;
  wire       hs_ivl   = (ivl_q != RST_IVL) & (ivl_q <= IVL_HS_MAX);
  wire       lc_short = cfg_line & (ivl_q != RST_IVL) & (ivl_q < IVL_LC_MIN);
  wire       start    = wr_ctrl & pwdata[CTRL_START];
  wire       errclr   = wr_ctrl & pwdata[CTRL_ERRCLR];
  wire       clr      = sys_rst | dev_clear;
  wire       known    = (ofs <= OFS_COUNT) & (ofs[1:0] == 2'h0);
  wire       bad_wr   = (wr_ivl & ~ivl_ok) | (wr_size & ~size_ok);
  wire       oneshot  = ivl_q == RST_IVL;
  wire       cont_md  = ~cfg_tmode[0];
  wire       ext_rise = ext_s2_q & ~ext_s3_q;

  // Trigger source for the pair that the mode selects
  logic trig_ev;
  always_comb begin
    unique case (tmode_q[2:1])
      2'h0: trig_ev = talk_addr;
      2'h1: trig_ev = get_cmd;
      2'h2: trig_ev = exec_char;
      2'h3: trig_ev = ext_rise;
    endcase
  end

  // One-shot needs a one-shot trigger mode high-speed needs valid setup
  wire start_bad = (oneshot & cont_md) | (hs_ivl & (~cfg_hsok | (size_q == RST_SIZE)));
  wire ms_tick   = ms_q == MS_CYC_M1;
  wire ivl_due   = ms_tick & (ivl_cnt_q + 24'h1 >= ivl_q);
  // Short period: store at every conversion, as fast as it runs
  wire time_ev   = lc_short ? conv_done : ivl_due;
  wire store_ev  = (st_q == RDS_RUN) & (oneshot ? trig_ev : time_ev);
  wire bounded   = size_q != RST_SIZE;
  wire last_slot = bounded & (cnt_q + 9'h1 == size_q);
  wire stat_full = st_q == RDS_FULL;

  wire out_step  = out_take & src_q & (cnt_q != 9'h0);
  wire [AW-1:0] rlim = bounded ? size_q : ((cnt_q == SIZE_MAX) ? SIZE_MAX : cnt_q);
  wire [RDW+AW-1:0] avg_w = (cnt_q == 9'h0) ? '0 : sum_q / (RDW+AW)'(cnt_q);
  wire [RDW-1:0] out_sel = src_q ? rd_word : (conv_done ? conv_data : live_q);

  assign pready  = 1'b1;
  assign pslverr = acc & (~known | bad_wr);
  assign rd_word = mem[rptr_q];

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers, restored by reset and device clear
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      src_q <= RST_SRC;
    end else if (wr_ctrl) begin
      src_q <= pwdata[CTRL_SRC];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      tmode_q <= RST_TMODE;
      hsok_q  <= 1'b0;
      line_q  <= 1'b0;
    end else if (wr_ctrl) begin
      tmode_q <= pwdata[CTRL_TMODE+2:CTRL_TMODE];
      hsok_q  <= pwdata[CTRL_HSOK];
      line_q  <= pwdata[CTRL_LINE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ivl_q <= RST_IVL;
    end else if (wr_ivl & ivl_ok) begin
      ivl_q <= pwdata[IW-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      size_q <= RST_SIZE;
    end else if (wr_size & size_ok) begin
      size_q <= pwdata[AW-1:0];
    end
  end

  // Error flags; a new error wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ioe_q <= 1'b0;
      spe_q <= 1'b0;
    end else begin
      ioe_q <= (start & start_bad) | (ioe_q & ~errclr);
      spe_q <= (start & ~start_bad & lc_short) | (spe_q & ~errclr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Store sequencer
  always_ff @(posedge sys_clk) begin
    if (clr | func_change) begin
      st_q <= RDS_IDLE;
    end else if (start) begin
      st_q <= start_bad ? RDS_IDLE : RDS_ARMED;
    end else begin
      unique case (st_q)
        RDS_IDLE:  st_q <= RDS_IDLE;
        RDS_ARMED: if (trig_ev) st_q <= RDS_RUN;
        RDS_RUN:   if (store_ev & last_slot) st_q <= RDS_FULL;
        RDS_FULL:  st_q <= RDS_FULL;
      endcase
    end
  end

  // Millisecond base and interval counter, restarted at storage start
  always_ff @(posedge sys_clk) begin
    if (clr | (st_q != RDS_RUN)) begin
      ms_q      <= 16'h0;
      ivl_cnt_q <= '0;
    end else begin
      ms_q <= ms_tick ? 16'h0 : ms_q + 16'h1;
      if (ms_tick) ivl_cnt_q <= ivl_due ? '0 : ivl_cnt_q + 24'h1;
    end
  end

  // Write pointer wraps over all locations in continuous mode
  always_ff @(posedge sys_clk) begin
    if (clr | start) begin
      wptr_q <= '0;
    end else if (store_ev) begin
      wptr_q <= (wptr_q == STORE_LAST) ? 9'h0 : wptr_q + 9'h1;
    end
  end

  // Count saturates at the depth so the read-back limit stays valid
  always_ff @(posedge sys_clk) begin
    if (clr | start) begin
      cnt_q <= '0;
    end else if (store_ev & (cnt_q != SIZE_MAX)) begin
      cnt_q <= cnt_q + 9'h1;
    end
  end

  // Running sum, highest and lowest of what was stored
  always_ff @(posedge sys_clk) begin
    if (clr | start) begin
      sum_q <= '0;
      max_q <= '0;
      min_q <= '1;
    end else if (store_ev) begin
      sum_q <= sum_q + (RDW+AW)'(conv_data);
      if (conv_data > max_q) max_q <= conv_data;
      if (conv_data < min_q) min_q <= conv_data;
    end
  end

  // Storage array; no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (store_ev) mem[wptr_q] <= conv_data;
  end

  // Read-back pointer restarts at the first location on source select
  always_ff @(posedge sys_clk) begin
    if (clr | (wr_ctrl & pwdata[CTRL_SRC])) begin
      rptr_q <= '0;
    end else if (out_step) begin
      rptr_q <= (rptr_q + 9'h1 >= rlim) ? 9'h0 : rptr_q + 9'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two flops for the pin, a third only to find its rising edge
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_trig;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      live_q <= '0;
    end else if (conv_done) begin
      live_q <= conv_data;
    end
  end

  // Bypass puts a fresh conversion on the output in the same cycle the live register takes it
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      out_data <= '0;
    end else begin
      out_data <= out_sel;
    end
  end

  assign store_full           = stat_full;
  assign illegal_option_error = ioe_q;
  assign short_period_error   = spe_q;

  // Read mux
  always_comb begin
    prdata = 32'h0;
    unique case (ofs)
      OFS_CTRL:  prdata = {22'h0, line_q, hsok_q, 1'b0, tmode_q, 3'h0, src_q};
      OFS_IVL:   prdata = {8'h0, ivl_q};
      OFS_SIZE:  prdata = {23'h0, size_q};
      OFS_STAT:  prdata = {26'h0, st_q, spe_q, ioe_q, stat_full, (st_q == RDS_RUN)};
      OFS_OUT:   prdata = {8'h0, out_data};
      OFS_MAX:   prdata = {8'h0, max_q};
      OFS_MIN:   prdata = {8'h0, min_q};
      OFS_AVG:   prdata = {8'h0, avg_w[RDW-1:0]};
      OFS_COUNT: prdata = {23'h0, cnt_q};
      default:   prdata = 32'h0;
    endcase
  end
endmodule : rds_ctrl

//--- test/rds_host_model.sv
// Bus controller model raising the trigger stimulus of each mode pair
`timescale 1ns/1ps
module rds_host_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] tmode,
  input  wire logic       fire,
  output logic            talk_addr,
  output logic            get_cmd,
  output logic            exec_char,
  output logic            ext_trig
);
  logic [1:0] ext_cnt_q = 2'h0;
  ////////////////////////////////////////
  always @(posedge sys_clk) begin
    talk_addr <= fire && tmode[2:1] == 2'h0;
    get_cmd   <= fire && tmode[2:1] == 2'h1;
    exec_char <= fire && tmode[2:1] == 2'h2;
    // Pulse held three cycles so the pin synchroniser sees it
    ext_cnt_q <= (fire && tmode[2:1] == 2'h3) ? 2'h3 : ext_cnt_q - {1'b0, ext_cnt_q != 2'h0};
  end
  assign ext_trig = ext_cnt_q != 2'h0;
endmodule : rds_host_model

//--- test/rds_ctrl_assertions.sv
// Port-level checker for the reading store controller
`timescale 1ns/1ps
module rds_ctrl_assertions (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        dev_clear,
  input wire logic        func_change,
  input wire logic        conv_done,
  input wire logic [23:0] conv_data,
  input wire logic [23:0] out_data,
  input wire logic        store_full,
  input wire logic        illegal_option_error,
  input wire logic        short_period_error
);
  import rds_pkg::*;
  logic src_q;
  wire  wr      = psel && penable && pready && pwrite && pstrb == 4'hf;
  wire  wr_ctrl = wr && paddr == 32'(OFS_CTRL);
  wire  errclr  = wr_ctrl && pwdata[CTRL_ERRCLR];
  ////////////////////////////////////////
  // Shadow of the source bit, needed since only ports are visible
  always_ff @(posedge sys_clk)
    if (sys_rst || dev_clear) src_q <= 1'b0;
    else if (wr_ctrl) src_q <= pwdata[CTRL_SRC];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_live; conv_done && !src_q && !wr_ctrl && !dev_clear; endsequence
  sequence s_quiet; !illegal_option_error && !short_period_error && !store_full; endsequence
  property p_live; s_live |=> out_data == $past(conv_data); endproperty
  property p_rst; $fell(sys_rst) |-> s_quiet; endproperty
  property p_clr; dev_clear |=> s_quiet; endproperty
  property p_func; func_change |=> !store_full; endproperty
  property p_hold; store_full && !wr && !func_change && !dev_clear |=> store_full; endproperty
  property p_ill; illegal_option_error && !errclr && !dev_clear |=> illegal_option_error; endproperty
  property p_short; short_period_error && !errclr && !dev_clear |=> short_period_error; endproperty
  property p_ready; psel && penable |-> pready; endproperty
  a_live: assert property (p_live) else $error("live output wrong");
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  a_clr: assert property (p_clr) else $error("outputs set after clear");
  a_func: assert property (p_func) else $error("store kept after function change");
  a_hold: assert property (p_hold) else $error("full store left");
  a_ill: assert property (p_ill) else $error("option error dropped");
  a_short: assert property (p_short) else $error("short period error dropped");
  a_ready: assert property (p_ready) else $error("access not answered");
endmodule : rds_ctrl_assertions
bind rds_ctrl rds_ctrl_assertions chk (.*);

//--- test/reading_data_store_control_tb.sv
// Self-checking bench for the reading store controller
`timescale 1ns/1ps
module reading_data_store_control_tb;
  import rds_pkg::*;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, dev_clear = 0, func_change = 0;
  logic conv_done = 0, out_take = 0, fire = 0, pready, pslverr, err, store_full, illegal_option_error;
  logic short_period_error, talk_addr, get_cmd, exec_char, ext_trig;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 0;
  logic [23:0] conv_data = 0, out_data, v[3];
  logic [2:0]  tm = 0;
  int          failures = 0, num_checks = 0, seed = 8205, n;
  rds_ctrl DUT (.*);
  rds_host_model host (.sys_clk, .tmode(tm), .fire, .talk_addr, .get_cmd, .exec_char, .ext_trig);
  initial forever #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic ck(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : ck
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {24'h0, a}; pwdata <= d; pstrb <= 4'hf;
    @(posedge sys_clk);
    penable <= 1;
    i = 0;
    do begin @(posedge sys_clk); i++; end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (i >= 20) begin failures++; wrap_up(); end
    repeat (2) @(posedge sys_clk);
  endtask : apb
  task automatic trig;
    fire <= 1;
    @(posedge sys_clk);
    fire <= 0;
    repeat (8) @(posedge sys_clk);
  endtask : trig
  function automatic logic [31:0] stat(int s);
    logic [31:0] mx, mn, sm;
    mx = v[0]; mn = v[0]; sm = 0;
    for (int k = 0; k < 3; k++) begin
      if (v[k] > mx) mx = v[k];
      if (v[k] < mn) mn = v[k];
      sm += v[k];
    end
    return s == 0 ? mx : s == 1 ? mn : sm / 3;
  endfunction : stat
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    for (int a = 0; a < 12; a += 4) begin apb(0, 8'(a), 0); ck("default", 0, rd); end
    apb(0, 8'h40, 0); ck("slverr", 1, err);
    $display("test defaults done");
    apb(1, OFS_CTRL, 0);
    repeat (6) begin
      conv_data <= $random(seed); conv_done <= 1; @(posedge sys_clk);
      conv_done <= 0; repeat (2) @(posedge sys_clk);
      ck("live", conv_data, out_data);
    end
    $display("test live done");
    apb(1, OFS_IVL, 0);
    for (int t = 0; t < 8; t += 2) begin
      apb(1, OFS_CTRL, 32'h1000 | t << 4); ck("illegal", 1, illegal_option_error);
      apb(1, OFS_CTRL, 32'h2000); ck("errclr", 0, illegal_option_error);
    end
    apb(1, OFS_IVL, 1); apb(1, OFS_CTRL, 32'h1010); ck("hs", 1, illegal_option_error);
    apb(1, OFS_IVL, 5); apb(1, OFS_CTRL, 32'h3210); ck("short", 1, short_period_error);
    apb(1, OFS_CTRL, 32'h2000);
    $display("test errors done");
    apb(1, OFS_IVL, 0); apb(1, OFS_SIZE, 3);
    for (int t = 1; t < 8; t += 2) begin
      tm <= t; apb(1, OFS_CTRL, 32'h1000 | t << 4); trig();
      apb(0, OFS_COUNT, 0); ck("count", 0, rd);
      for (int k = 0; k < 3; k++) begin v[k] = $random(seed) & 24'h7fffff; conv_data <= v[k]; trig(); end
      ck("full", 1, store_full);
      conv_data <= 0; trig(); apb(0, OFS_COUNT, 0); ck("count", 3, rd);
      apb(1, OFS_CTRL, 1 | t << 4);
      for (int k = 0; k < 4; k++) begin
        ck("stored", v[k % 3], out_data);
        out_take <= 1; @(posedge sys_clk); out_take <= 0; repeat (2) @(posedge sys_clk);
      end
    end
    for (int s = 0; s < 3; s++) begin apb(0, 8'(OFS_MAX + 4 * s), 0); ck("stat", stat(s), rd); end
    func_change <= 1; @(posedge sys_clk); func_change <= 0; repeat (2) @(posedge sys_clk);
    ck("func", 0, store_full);
    $display("test one-shot done");
    tm <= 1; apb(1, OFS_SIZE, 0); apb(1, OFS_CTRL, 32'h1010); trig();
    for (int k = 1; k <= 501; k++) begin conv_data <= 24'(k); trig(); end
    apb(0, OFS_COUNT, 0); ck("wrap count", 500, rd); ck("wrap full", 0, store_full);
    apb(1, OFS_CTRL, 32'h11); ck("wrap first", 501, out_data);
    out_take <= 1; @(posedge sys_clk); out_take <= 0; repeat (2) @(posedge sys_clk);
    ck("wrap next", 2, out_data);
    $display("test wrap done");
    tm <= 2; apb(1, OFS_IVL, 1); apb(1, OFS_SIZE, 2); apb(1, OFS_CTRL, 32'h1120); trig();
    n = 0;
    while (store_full !== 1'b1 && n < 60000) begin @(posedge sys_clk); n++; end
    ck("ms", 1, n > 2 * MS_CYC - 100 && n <= 2 * MS_CYC);
    $display("test timed done");
    apb(1, OFS_IVL, 7); dev_clear <= 1; @(posedge sys_clk); dev_clear <= 0; @(posedge sys_clk);
    apb(0, OFS_IVL, 0); ck("clear", 0, rd);
    $display("test clear done");
    wrap_up();
  end
endmodule : reading_data_store_control_tb
